//--- src/rsp_port.sv
`timescale 1ns/10ps
// Functional notes
// - Exactly one remote interface active; parallel bus is the default.
// - Interface choice is kept in non-volatile storage across resets.
// - Switching the active interface clears the reading data buffer.
// - Interface choice comes only from front-panel controls.
// - Turning the serial interface off selects the parallel bus.
// - Characters are eight data bits, no parity, one stop bit.
// - Control-C or Control-X aborts pending work and drops unsent output.
// - Seven selectable rates, 19.2k down to 300, default 4800.
// - No hardware flow control; clear-to-send and request-to-send are ignored.
// - With software flow, send XOFF when receive queue exceeds three quarters.
// - After XOFF, send XON once the queue falls below half.
// - With software flow, incoming XOFF halts transmission until XON; a received Control-C or Control-X also ends the halt.
// - Commands are buffered and passed on as they arrive; a queued carriage return raises o_cmd_pending.
// - Without flow control, characters arriving when full are lost.
// - Each transmitted message ends with LF, CR or LF then CR.
// - Only transmit data, receive data and ground are used.
module rsp_port #(
    parameter int RXQ_DEPTH = rsp_pkg::RXQ_DEPTH
) (
    input wire logic i_sys_clk,                  // 25 MHz system clock.
    input wire logic i_reset,                    // Synchronous active-high reset.
    input wire logic i_panel_if_we,              // Front-panel interface write strobe.
    input wire logic i_panel_serial_on,          // Front-panel serial on/off choice.
    input wire logic i_nv_serial_sel,            // Stored choice read back from NV memory.
    input wire logic i_nv_valid,                 // NV memory read-back is valid.
    output logic o_nv_we,                        // Pulse to write the NV memory.
    output logic o_nv_serial_sel,                // Value to write to NV memory.
    output logic o_serial_active,                // Serial port is the active interface.
    output logic o_parallel_active,              // Parallel bus is the active interface.
    output logic o_reading_buf_clear,            // Pulse clearing the reading data buffer.
    input wire rsp_pkg::rsp_cfg_t i_cfg,         // Rate, flow and terminator settings.
    input wire logic i_rxd,                      // Receive data pin.
    output logic o_txd,                          // Transmit data pin.
    output logic o_cmd_valid,                    // Command character available.
    input wire logic i_cmd_ready,                // Command consumer accepts a character.
    output logic [7:0] o_cmd_data,               // Command character.
    output logic o_cmd_pending,                  // A carriage return is queued or the queue is full.
    output logic o_abort,                        // Pulse on a break character.
    input wire logic i_tx_valid,                 // Response character offered.
    output logic o_tx_ready,                     // Response character accepted.
    input wire rsp_pkg::rsp_tx_char_t i_tx_char, // Response character and end-of-message.
    output logic o_tx_halted,                    // Output held by a received XOFF.
    output logic o_rx_overrun,                   // Pulse when a character is lost.
    output logic o_frame_error                   // Pulse on a missing stop bit.
);
    // ------------------------------------------------------------------
    // Interface selection
    // ------------------------------------------------------------------
    // The selection register mirrors NV storage; reset loads the parallel default
    // and the stored copy is reloaded once i_nv_valid is first seen.
    logic sel_serial_q;
    logic nv_loaded_q;
    logic sel_next;
    logic sel_change;

    always_comb begin
        sel_next = sel_serial_q;
        if (!nv_loaded_q && i_nv_valid) begin
            sel_next = i_nv_serial_sel;
        end else if (i_panel_if_we && nv_loaded_q) begin
            sel_next = i_panel_serial_on;
        end
    end
    assign sel_change = nv_loaded_q && i_panel_if_we && (i_panel_serial_on != sel_serial_q);

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            nv_loaded_q <= 1'b0;
            sel_serial_q <= 1'b0;
        end else begin
            if (i_nv_valid) begin
                nv_loaded_q <= 1'b1;
            end
            sel_serial_q <= sel_next;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_nv_we <= 1'b0;
            o_nv_serial_sel <= 1'b0;
            o_reading_buf_clear <= 1'b0;
        end else begin
            o_nv_we <= sel_change;
            o_nv_serial_sel <= i_panel_serial_on;
            o_reading_buf_clear <= sel_change;
        end
    end

    assign o_serial_active = sel_serial_q;
    assign o_parallel_active = !sel_serial_q;

    // ------------------------------------------------------------------
    // Rate divider
    // ------------------------------------------------------------------
    // One tick is one sixteenth of a bit; the residual rate error is
    // below 0.2 percent at 4800 and below, about 0.47 percent at 19.2k and 9600.
    function automatic logic [rsp_pkg::DIV_W-1:0] div_of(input int unsigned baud);
        return rsp_pkg::DIV_W'(rsp_pkg::CLK_HZ / (baud * rsp_pkg::OVERSAMPLE) - 1);
    endfunction

    logic [rsp_pkg::DIV_W-1:0] div_load;
    logic [rsp_pkg::DIV_W-1:0] div_q;
    logic tick;

    always_comb begin
        case (i_cfg.baud_sel)
            3'h0: div_load = div_of(rsp_pkg::BAUD_19200);
            3'h1: div_load = div_of(rsp_pkg::BAUD_9600);
            3'h2: div_load = div_of(rsp_pkg::BAUD_4800);
            3'h3: div_load = div_of(rsp_pkg::BAUD_2400);
            3'h4: div_load = div_of(rsp_pkg::BAUD_1200);
            3'h5: div_load = div_of(rsp_pkg::BAUD_600);
            3'h6: div_load = div_of(rsp_pkg::BAUD_300);
            default: div_load = div_of(rsp_pkg::BAUD_4800);
        endcase
    end
    assign tick = (div_q == '0);

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || tick) begin
            div_q <= div_load;
        end else begin
            div_q <= div_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rsp_rx_st_t;

    logic rxd_meta_q;
    logic rxd_q;
    rsp_rx_st_t rx_st_q;
    logic [3:0] rx_os_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_shift_q;
    logic rx_done;
    logic rx_stop_ok;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rxd_meta_q <= 1'b1;
            rxd_q <= 1'b1;
        end else begin
            rxd_meta_q <= i_rxd;
            rxd_q <= rxd_meta_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rx_st_q <= RX_IDLE;
            rx_os_q <= '0;
            rx_bit_q <= '0;
            rx_shift_q <= '0;
        end else if (tick) begin
            rx_os_q <= rx_os_q + 1'b1;
            case (rx_st_q)
                RX_IDLE: begin
                    rx_os_q <= '0;
                    if (!rxd_q) begin
                        rx_st_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_os_q == 4'(rsp_pkg::MID_SAMPLE)) begin
                        rx_os_q <= '0;
                        rx_bit_q <= '0;
                        rx_st_q <= rxd_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_os_q == 4'(rsp_pkg::OS_LAST)) begin
                        rx_shift_q <= {rxd_q, rx_shift_q[7:1]};
                        rx_bit_q <= rx_bit_q + 1'b1;
                        if (rx_bit_q == 3'(rsp_pkg::DATA_BITS - 1)) begin
                            rx_st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_os_q == 4'(rsp_pkg::OS_LAST)) begin
                        rx_st_q <= RX_IDLE;
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    assign rx_done = tick && (rx_st_q == RX_STOP) && (rx_os_q == 4'(rsp_pkg::OS_LAST));
    assign rx_stop_ok = rx_done && rxd_q;

    // ------------------------------------------------------------------
    // Received character handling
    // ------------------------------------------------------------------
    logic is_break;
    logic is_flow_char;
    logic q_push;
    logic q_ready;
    logic [$clog2(RXQ_DEPTH+1)-1:0] q_count;
    logic cr_cnt_inc;
    logic cr_cnt_dec;
    logic [$clog2(RXQ_DEPTH+1)-1:0] cr_cnt_q;
    logic tx_hold_q;
    logic flush;

    assign is_break = (rx_shift_q == rsp_pkg::CH_CTRL_C) || (rx_shift_q == rsp_pkg::CH_CTRL_X);
    assign is_flow_char = i_cfg.software_flow_option &&
        ((rx_shift_q == rsp_pkg::CH_XON) || (rx_shift_q == rsp_pkg::CH_XOFF));
    assign flush = rx_stop_ok && is_break && sel_serial_q;
    assign q_push = rx_stop_ok && sel_serial_q && !is_break && !is_flow_char;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_abort <= 1'b0;
            o_rx_overrun <= 1'b0;
            o_frame_error <= 1'b0;
        end else begin
            o_abort <= flush;
            o_rx_overrun <= q_push && !q_ready;
            o_frame_error <= rx_done && !rxd_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || !i_cfg.software_flow_option || flush) begin
            tx_hold_q <= 1'b0;
        end else if (rx_stop_ok && rx_shift_q == rsp_pkg::CH_XOFF) begin
            tx_hold_q <= 1'b1;
        end else if (rx_stop_ok && rx_shift_q == rsp_pkg::CH_XON) begin
            tx_hold_q <= 1'b0;
        end
    end
    assign o_tx_halted = tx_hold_q;

    rsp_fifo #(
        .WIDTH(8),
        .DEPTH(RXQ_DEPTH)
    ) u_rxq (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_flush(flush || !sel_serial_q),
        .i_valid(q_push),
        .o_ready(q_ready),
        .i_data(rx_shift_q),
        .o_valid(o_cmd_valid),
        .i_ready(i_cmd_ready),
        .o_data(o_cmd_data),
        .o_count(q_count)
    );

    // Characters go to the parser as they arrive; queued carriage returns are counted for o_cmd_pending.
    assign cr_cnt_inc = q_push && q_ready && (rx_shift_q == rsp_pkg::CH_CR);
    assign cr_cnt_dec = o_cmd_valid && i_cmd_ready && (o_cmd_data == rsp_pkg::CH_CR);
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || flush || !sel_serial_q) begin
            cr_cnt_q <= '0;
        end else begin
            cr_cnt_q <= cr_cnt_q + (cr_cnt_inc ? 1'b1 : 1'b0) - (cr_cnt_dec ? 1'b1 : 1'b0);
        end
    end
    assign o_cmd_pending = (cr_cnt_q != '0) || !q_ready;

    // ------------------------------------------------------------------
    // Flow control requests
    // ------------------------------------------------------------------
    logic above_hi;
    logic below_lo;
    logic xoff_sent_q;
    logic send_xoff_q;
    logic send_xon_q;
    logic fc_taken;

    assign above_hi = (32'(q_count) * 4) > (RXQ_DEPTH * 3);
    assign below_lo = (32'(q_count) * 2) < RXQ_DEPTH;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || !i_cfg.software_flow_option) begin
            xoff_sent_q <= 1'b0;
            send_xoff_q <= 1'b0;
            send_xon_q <= 1'b0;
        end else if (fc_taken) begin
            send_xoff_q <= 1'b0;
            send_xon_q <= 1'b0;
        end else if (!xoff_sent_q && above_hi) begin
            xoff_sent_q <= 1'b1;
            send_xoff_q <= 1'b1;
        end else if (xoff_sent_q && below_lo) begin
            xoff_sent_q <= 1'b0;
            send_xoff_q <= 1'b0;
            send_xon_q <= !send_xoff_q;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_SEND = 4'b0010,
        TX_TERM1 = 4'b0100,
        TX_TERM2 = 4'b1000
    } rsp_tx_st_t;

    rsp_tx_st_t tx_st_q;
    logic [9:0] tx_frame_q;
    logic [3:0] tx_os_q;
    logic [3:0] tx_bits_q;
    logic tx_busy;
    logic tx_load;
    logic [7:0] tx_load_char;
    logic [7:0] term_first;

    assign tx_busy = (tx_bits_q != '0);
    assign term_first = (i_cfg.term == rsp_pkg::RSP_TERM_CR) ? rsp_pkg::CH_CR : rsp_pkg::CH_LF;
    // Flow characters go out even while output is held, or a deadlock follows.
    assign fc_taken = !tx_busy && sel_serial_q && (send_xoff_q || send_xon_q);
    assign o_tx_ready = (tx_st_q == TX_IDLE) && !tx_busy && !fc_taken && !tx_hold_q && sel_serial_q;

    always_comb begin
        tx_load = 1'b0;
        tx_load_char = '0;
        if (fc_taken) begin
            tx_load = 1'b1;
            tx_load_char = send_xoff_q ? rsp_pkg::CH_XOFF : rsp_pkg::CH_XON;
        end else if (!tx_busy && !tx_hold_q && sel_serial_q) begin
            case (tx_st_q)
                TX_IDLE: begin
                    tx_load = i_tx_valid;
                    tx_load_char = i_tx_char.data;
                end
                TX_TERM1: begin
                    tx_load = 1'b1;
                    tx_load_char = term_first;
                end
                TX_TERM2: begin
                    tx_load = 1'b1;
                    tx_load_char = rsp_pkg::CH_CR;
                end
                default: tx_load = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || flush || !sel_serial_q) begin
            tx_st_q <= TX_IDLE;
        end else if (tx_load && !fc_taken) begin
            case (tx_st_q)
                TX_IDLE: tx_st_q <= i_tx_char.last ? TX_TERM1 : TX_IDLE;
                TX_TERM1: tx_st_q <= (i_cfg.term == rsp_pkg::RSP_TERM_LFCR) ? TX_TERM2 : TX_IDLE;
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            tx_frame_q <= '1;
            tx_os_q <= '0;
            tx_bits_q <= '0;
        end else if (tx_load) begin
            tx_frame_q <= {1'b1, tx_load_char, 1'b0};
            tx_os_q <= '0;
            tx_bits_q <= 4'(rsp_pkg::DATA_BITS + 2);
        end else if (tick && tx_busy) begin
            tx_os_q <= tx_os_q + 1'b1;
            if (tx_os_q == 4'(rsp_pkg::OS_LAST)) begin
                tx_frame_q <= {1'b1, tx_frame_q[9:1]};
                tx_bits_q <= tx_bits_q - 1'b1;
            end
        end
    end

    assign o_txd = tx_frame_q[0];
endmodule

//--- src/rsp_pkg.sv
package rsp_pkg;

    // ------------------------------------------------------------------
    // Clock and bit rates
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int unsigned MID_SAMPLE = 7;
    localparam int unsigned OS_LAST = 15;
    localparam int unsigned DIV_W = 16;
    // Bit rates, one per selectable rate, index 0 is 19.2k.
    localparam int unsigned BAUD_19200 = 19200;
    localparam int unsigned BAUD_9600 = 9600;
    localparam int unsigned BAUD_4800 = 4800;
    localparam int unsigned BAUD_2400 = 2400;
    localparam int unsigned BAUD_1200 = 1200;
    localparam int unsigned BAUD_600 = 600;
    localparam int unsigned BAUD_300 = 300;
    localparam logic [2:0] BAUD_SEL_RESET = 3'h2;

    // ------------------------------------------------------------------
    // Characters
    // ------------------------------------------------------------------
    localparam logic [7:0] CH_XON = 8'h11;
    localparam logic [7:0] CH_XOFF = 8'h13;
    localparam logic [7:0] CH_CTRL_C = 8'h03;
    localparam logic [7:0] CH_CTRL_X = 8'h18;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam int unsigned DATA_BITS = 8;

    // ------------------------------------------------------------------
    // Input queue
    // ------------------------------------------------------------------
    localparam int unsigned RXQ_DEPTH = 4;

    typedef enum logic [1:0] {
        RSP_TERM_LF = 2'h0,
        RSP_TERM_CR = 2'h1,
        RSP_TERM_LFCR = 2'h2
    } rsp_term_t;

    typedef enum logic [1:0] {
        RSP_IF_PARALLEL = 2'h0,
        RSP_IF_SERIAL = 2'h1
    } rsp_if_t;

    typedef struct packed {
        logic [2:0] baud_sel;
        logic software_flow_option;
        rsp_term_t term;
    } rsp_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } rsp_tx_char_t;

endpackage

//--- src/rsp_fifo.sv
`timescale 1ns/10ps
module rsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_sys_clk,              // System clock.
    input wire logic i_reset,                // Synchronous reset.
    input wire logic i_flush,                // Drop all contents.
    input wire logic i_valid,                // Write request.
    output logic o_ready,                    // Space available.
    input wire logic [WIDTH-1:0] i_data,     // Write data.
    output logic o_valid,                    // Data available.
    input wire logic i_ready,                // Read accept.
    output logic [WIDTH-1:0] o_data,         // Read data.
    output logic [$clog2(DEPTH+1)-1:0] o_count // Occupancy.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [$clog2(DEPTH+1)-1:0] cnt_q;
    logic push;
    logic pop;

    assign o_ready = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign o_valid = (cnt_q != '0);
    assign o_data = mem_q[rd_q];
    assign o_count = cnt_q;
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || i_flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule

//--- test/rsp_port_chk.sv
`timescale 1ns/10ps
module rsp_port_chk (
    input wire logic i_sys_clk,           // Clock.
    input wire logic i_reset,             // Reset.
    input wire logic i_panel_if_we,       // Panel strobe.
    input wire logic i_panel_serial_on,   // Panel choice.
    input wire logic i_nv_valid,          // Stored copy valid.
    input wire logic o_nv_we,             // Store pulse.
    input wire logic o_nv_serial_sel,     // Stored value.
    input wire logic o_serial_active,     // Serial active.
    input wire logic o_parallel_active,   // Parallel active.
    input wire logic o_reading_buf_clear, // Buffer clear.
    input wire logic i_tx_valid,          // Tx offer.
    input wire logic o_tx_ready,          // Tx accept.
    input wire logic o_txd,               // Tx pin.
    input wire logic o_cmd_valid,         // Queue output.
    input wire logic o_abort,             // Break pulse.
    input wire logic o_tx_halted          // Held by XOFF.
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_one_active: assert property (o_serial_active != o_parallel_active)
        else $error("interface selection not exclusive");
    a_panel_on: assert property (i_panel_if_we && i_panel_serial_on && o_parallel_active && $past(i_nv_valid)
        |=> o_serial_active && o_nv_we && o_reading_buf_clear) else $error("serial select not taken");
    a_panel_off: assert property (i_panel_if_we && !i_panel_serial_on && o_serial_active && $past(i_nv_valid)
        |=> o_parallel_active && o_reading_buf_clear) else $error("parallel not selected");
    a_clear_change: assert property (o_reading_buf_clear |-> $changed(o_serial_active))
        else $error("buffer clear without switch");
    a_store_value: assert property (o_nv_we |-> o_nv_serial_sel == o_serial_active)
        else $error("stored choice differs");
    a_store_change: assert property (o_nv_we |-> $changed(o_serial_active))
        else $error("store without change");
    a_tx_start: assert property (i_tx_valid && o_tx_ready |=> !o_txd)
        else $error("no start bit");
    a_tx_busy: assert property (i_tx_valid && o_tx_ready |=> !o_tx_ready [*8])
        else $error("accepted during frame");
    a_abort_flush: assert property (o_abort |-> ##1 !o_cmd_valid)
        else $error("queue kept after break");
    a_halt_ready: assert property (o_tx_halted |-> !o_tx_ready)
        else $error("sending while halted");
    c_switch: cover property (o_nv_we);
    c_abort: cover property (o_abort);
    c_tx: cover property (i_tx_valid && o_tx_ready);
    c_halt: cover property (o_tx_halted);
endmodule

//--- test/rsp_host.sv
`timescale 1ns/10ps
module rsp_host #(
    parameter int BIT_NS = 51840,
    parameter int GAP_NS = 0
) (
    input wire logic i_txd, // Device transmit pin.
    output logic o_rxd      // Device receive pin.
);
    logic [7:0] got[$];
    logic paused = 1'b0;
    initial o_rxd = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        int i;
        wait (!paused);
        o_rxd = 1'b0;
        #(BIT_NS);
        for (i = 0; i < 8; i++) begin
            o_rxd = b[i];
            #(BIT_NS);
        end
        o_rxd = 1'b1;
        #(BIT_NS + GAP_NS);
    endtask
    initial begin : rx
        logic [7:0] b;
        forever begin
            @(negedge i_txd);
            #(BIT_NS / 2);
            for (int i = 0; i < 8; i++) begin
                #(BIT_NS);
                b[i] = i_txd;
            end
            #(BIT_NS);
            if (i_txd === 1'b1) begin
                got.push_back(b);
                if (b == rsp_pkg::CH_XOFF) paused = 1'b1;
                if (b == rsp_pkg::CH_XON) paused = 1'b0;
            end
        end
    end
endmodule

//--- test/rsp_port_tb.sv
`timescale 1ns/10ps
module rsp_port_tb;
    logic clk, rst, we, on, nvs, nvv, cmd_rdy, tx_v, rxd;
    logic nv_we, nv_sel, ser, par, bclr, txd, cmd_v, pend, abort, tx_rdy, halted, ovr, ferr;
    logic [7:0] cmd_d;
    rsp_pkg::rsp_cfg_t cfg;
    rsp_pkg::rsp_tx_char_t txc;
    int n_errors = 0;
    int tests_run = 0;
    int k;
    rsp_port i_rsp_port (.i_sys_clk(clk), .i_reset(rst), .i_panel_if_we(we), .i_panel_serial_on(on),
        .i_nv_serial_sel(nvs), .i_nv_valid(nvv), .o_nv_we(nv_we), .o_nv_serial_sel(nv_sel),
        .o_serial_active(ser), .o_parallel_active(par), .o_reading_buf_clear(bclr), .i_cfg(cfg),
        .i_rxd(rxd), .o_txd(txd), .o_cmd_valid(cmd_v), .i_cmd_ready(cmd_rdy), .o_cmd_data(cmd_d),
        .o_cmd_pending(pend), .o_abort(abort), .i_tx_valid(tx_v), .o_tx_ready(tx_rdy), .i_tx_char(txc),
        .o_tx_halted(halted), .o_rx_overrun(ovr), .o_frame_error(ferr));
    rsp_host i_rsp_host (.i_txd(txd), .o_rxd(rxd));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Any wait that runs past its bound ends the run here.
    task automatic guard(input int n);
        if (n >= 30000) begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic panel(input logic v);
        @(posedge clk);
        we <= 1'b1;
        on <= v;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask
    task automatic wait_abort();
        for (k = 0; k < 30000 && abort !== 1'b1; k++) @(negedge clk);
        guard(k);
    endtask
    always @(negedge clk) begin
        if (!rst && (ovr !== 1'b0 || ferr !== 1'b0)) check({ovr, ferr}, 2'h0);
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst, we, on, nvs, nvv, cmd_rdy, tx_v} = 7'h40;
        cfg = '{3'h0, 1'b0, rsp_pkg::RSP_TERM_LFCR};
        txc = '{8'h00, 1'b0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        nvv <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(par, 1'b1);
        check(txd, 1'b1);
        panel(1'b1);
        check({ser, par, bclr, nv_we, nv_sel}, 5'h17);
        i_rsp_host.send_byte(8'h41);
        for (k = 0; k < 30000 && cmd_v !== 1'b1; k++) @(posedge clk);
        guard(k);
        #1;
        check(cmd_d, 8'h41);
        check(pend, 1'b0);
        i_rsp_host.send_byte(rsp_pkg::CH_CR);
        for (k = 0; k < 30000 && pend !== 1'b1; k++) @(posedge clk);
        guard(k);
        @(posedge clk);
        tx_v <= 1'b1;
        txc <= '{8'h4b, 1'b1};
        #1;
        for (k = 0; k < 30000 && tx_rdy !== 1'b1; k++) @(negedge clk);
        guard(k);
        @(posedge clk);
        tx_v <= 1'b0;
        for (k = 0; k < 30000 && i_rsp_host.got.size() < 2; k++) @(posedge clk);
        guard(k);
        for (k = 0; k < 30000 && i_rsp_host.got.size() < 3; k++) @(posedge clk);
        guard(k);
        check(i_rsp_host.got[0], 8'h4b);
        check(i_rsp_host.got[1], rsp_pkg::CH_LF);
        check(i_rsp_host.got[2], rsp_pkg::CH_CR);
        cfg <= '{3'h0, 1'b1, rsp_pkg::RSP_TERM_LFCR};
        i_rsp_host.send_byte(rsp_pkg::CH_XOFF);
        check({halted, tx_rdy, cmd_v}, 3'h5);
        fork
            i_rsp_host.send_byte(rsp_pkg::CH_CTRL_C);
            wait_abort();
        join
        repeat (2) @(posedge clk);
        #1;
        check({cmd_v, pend, halted}, 3'h0);
        panel(1'b0);
        check({ser, par, bclr}, 3'h3);
        give_verdict();
    end
endmodule
bind rsp_port rsp_port_chk i_rsp_port_chk (.i_sys_clk, .i_reset, .i_panel_if_we, .i_panel_serial_on,
    .i_nv_valid, .o_nv_we, .o_nv_serial_sel, .o_serial_active, .o_parallel_active, .o_reading_buf_clear,
    .i_tx_valid, .o_tx_ready, .o_txd, .o_cmd_valid, .o_abort, .o_tx_halted);
